// ===== src/ulm_core.sv
// Partial-word and zero-extended word load datapath with APB configuration.
// Assumes translation answers combinationally and memory answers later,
// all on pclk; register file and bypass values arrive on pclk as well.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module ulm_core
	import ulm_pkg::*;
#(
	parameter int PADDR_W = 32,
	parameter int COUNT_W = 32
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [11:0]          paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 issue_valid,
	output logic                      issue_ready,
	input  wire logic [31:0]          issue_instr,
	input  wire logic [63:0]          base_value,
	input  wire logic [63:0]          target_value,
	input  wire ulm_result_type       bypass_in,
	output logic [63:0]               virtual_addr,
	input  wire logic [PADDR_W-1:0]   xlat_paddr,
	output logic                      mem_req_valid,
	input  wire logic                 mem_req_ready,
	output logic [PADDR_W-1:0]        mem_paddr,
	output logic [2:0]                mem_access_type,
	input  wire logic                 mem_rsp_valid,
	input  wire logic [63:0]          mem_rsp_data,
	output ulm_result_type            result_out,
	output logic                      addr_error,
	output logic                      reserved_instr
);

	// Parameter values the logic cannot serve
	if (PADDR_W < 3 || PADDR_W > 64 ||
		COUNT_W < 1 || COUNT_W > 32) begin : g_param_check
		$error("ulm_core: unsupported parameter values");
	end

	ulm_state_type  state_r;
	ulm_kind_type   kind_r;
	ulm_cfg_type    cfg;
	ulm_result_type last_r;
	logic [31:0]        ctrl_r;
	logic               sticky_addr_r;
	logic               sticky_rsvd_r;
	logic [COUNT_W-1:0] count_r;
	logic [63:0]        virtual_addr_r;
	logic [63:0]        old_r;
	logic [4:0]         tgt_r;
	logic [1:0]         byte_r;
	logic               word_r;
	logic               mode64_r;
	logic [PADDR_W-1:0] paddr_r;
	logic [2:0]         atype_r;
	logic               req_valid_r;
	logic [31:0]        prdata_r;
	logic               addr_err_r;
	logic               rsvd_r;

	logic [5:0]   opc;
	logic [4:0]   tgt;
	logic [63:0]  disp_ext;
	logic [63:0]  sum;
	logic [63:0]  virtual_addr_nxt;
	logic         is_left;
	logic         is_right;
	logic         is_zext;
	logic         take;
	logic         zext_misalign;
	logic         zext_rsvd;
	logic         good_issue;
	logic [63:0]  old_nxt;
	logic [PADDR_W-1:0] paddr_nxt;
	logic         apb_setup;
	logic         apb_wr;
	logic         mapped;
	logic         wb_fire;
	logic [31:0]  merged;
	logic [63:0]  wb_data;

	assign cfg = {ctrl_r[CTRL_MODE64],
		ctrl_r[CTRL_PRIV_HI:CTRL_PRIV_LO],
		ctrl_r[CTRL_MEM_BE],
		ctrl_r[CTRL_CPU_BE],
		ctrl_r[CTRL_REV]};

	// Left-partial merge: top of the low word downward
	function automatic logic [31:0] merge_left(
		input logic [63:0] m,
		input logic [31:0] old,
		input logic [1:0]  b,
		input logic        w
	);
		logic [31:0] t;
		int          sh;
		int          base;
		t = old;
		sh = 3 - int'(b);
		base = w ? 4 : 0;
		for (int i = 0; i < 4; i++) begin
			if (i >= sh) begin
				t[8*i +: 8] = m[8*(base + i - sh) +: 8];
			end
		end
		return t;
	endfunction : merge_left

	// Right-partial merge: low byte upward within the addressed word
	function automatic logic [31:0] merge_right(
		input logic [63:0] m,
		input logic [31:0] old,
		input logic [1:0]  b,
		input logic        w
	);
		logic [31:0] t;
		int          top;
		int          base;
		t = old;
		top = 3 - int'(b);
		base = (w ? 4 : 0) + int'(b);
		for (int i = 0; i < 4; i++) begin
			if (i <= top) begin
				t[8*i +: 8] = m[8*(base + i) +: 8];
			end
		end
		return t;
	endfunction : merge_right

	// Instruction decode
	assign opc      = issue_instr[OPC_HI:OPC_LO];
	assign tgt      = issue_instr[TGT_HI:TGT_LO];
	assign is_left  = (opc == OP_LOAD_LEFT);
	assign is_right = (opc == OP_LOAD_RIGHT);
	assign is_zext  = (opc == OP_LOAD_ZEXT);
	assign take     = issue_valid && issue_ready;

	// Effective address
	assign disp_ext = {{48{issue_instr[DISP_HI]}}, issue_instr[DISP_HI:0]};
	assign sum      = base_value + disp_ext;
	assign virtual_addr_nxt = cfg.mode64 ? sum : {{32{sum[31]}}, sum[31:0]};

	// Exceptions; partial loads have no alignment check
	assign zext_misalign = is_zext && (virtual_addr_nxt[1:0] != 2'h0);
	assign zext_rsvd = is_zext && !cfg.mode64 &&
		(cfg.priv == PRIV_USER || cfg.priv == PRIV_SUPER);
	assign good_issue = take && (is_left || is_right || is_zext) &&
		!zext_misalign && !zext_rsvd;

	// Old target value with forwarding from the preceding load
	always_comb begin
		if (last_r.valid && last_r.target_reg == tgt) begin
			old_nxt = last_r.data;
		end else if (bypass_in.valid && bypass_in.target_reg == tgt) begin
			old_nxt = bypass_in.data;
		end else begin
			old_nxt = target_value;
		end
	end

	assign issue_ready  = (state_r == ST_IDLE);
	assign virtual_addr = virtual_addr_r;

	// Sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (good_issue) begin
						state_r <= ST_XLAT;
					end
				end
				ST_XLAT: begin
					state_r <= ST_REQ;
				end
				ST_REQ: begin
					if (mem_req_ready) begin
						state_r <= ST_RESP;
					end
				end
				ST_RESP: begin
					if (mem_rsp_valid) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Captured load context; mode64 and processor_big_endian sampled per load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			virtual_addr_r  <= 64'h0;
			old_r    <= 64'h0;
			tgt_r    <= 5'h0;
			kind_r   <= KIND_LEFT;
			byte_r   <= 2'h0;
			word_r   <= 1'b0;
			mode64_r <= 1'b0;
		end else if (good_issue) begin
			virtual_addr_r  <= virtual_addr_nxt;
			old_r    <= old_nxt;
			tgt_r    <= tgt;
			kind_r   <= is_left ? KIND_LEFT : (is_right ? KIND_RIGHT : KIND_ZEXT);
			byte_r   <= virtual_addr_nxt[1:0] ^ {2{cfg.processor_big_endian}};
			word_r   <= virtual_addr_nxt[2] ^ cfg.processor_big_endian;
			mode64_r <= cfg.mode64;
		end
	end

	// Physical address adjustment and access type
	always_comb begin
		paddr_nxt = xlat_paddr;
		paddr_nxt[2:0] = xlat_paddr[2:0] ^ {3{cfg.endian_reverse_select}};
		if (kind_r == KIND_LEFT && !cfg.memory_big_endian) begin
			paddr_nxt[1:0] = 2'h0;
		end
		if (kind_r == KIND_RIGHT && cfg.memory_big_endian) begin
			paddr_nxt[2:0] = 3'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			paddr_r     <= '0;
			atype_r     <= 3'h0;
			req_valid_r <= 1'b0;
		end else if (state_r == ST_XLAT) begin
			paddr_r     <= paddr_nxt;
			req_valid_r <= 1'b1;
			case (kind_r)
				KIND_LEFT: atype_r <= {1'b0, byte_r};
				KIND_RIGHT: atype_r <= {1'b0, BYTE_TOP - byte_r};
				default: atype_r <= ATYPE_WORD;
			endcase
		end else if (state_r == ST_REQ && mem_req_ready) begin
			req_valid_r <= 1'b0;
		end
	end

	assign mem_req_valid   = req_valid_r;
	assign mem_paddr       = paddr_r;
	assign mem_access_type = atype_r;

	// Merge and extension
	assign wb_fire = (state_r == ST_RESP) && mem_rsp_valid;

	always_comb begin
		if (kind_r == KIND_LEFT) begin
			merged = merge_left(mem_rsp_data, old_r[31:0], byte_r, word_r);
		end else if (kind_r == KIND_RIGHT) begin
			merged = merge_right(mem_rsp_data, old_r[31:0], byte_r, word_r);
		end else begin
			merged = word_r ? mem_rsp_data[63:32] : mem_rsp_data[31:0];
		end
		if (kind_r == KIND_ZEXT) begin
			wb_data = {32'h0, merged};
		end else if (mode64_r) begin
			wb_data = {{32{merged[31]}}, merged};
		end else begin
			wb_data = {old_r[63:32], merged};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_out <= '0;
		end else begin
			result_out.valid <= wb_fire;
			if (wb_fire) begin
				result_out.target_reg <= tgt_r;
				result_out.data       <= wb_data;
			end
		end
	end

	// Last own result, valid only for the next issued load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= '0;
		end else if (wb_fire) begin
			last_r.valid      <= 1'b1;
			last_r.target_reg <= tgt_r;
			last_r.data       <= wb_data;
		end else if (take) begin
			last_r.valid <= 1'b0;
		end
	end

	// Exception pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_err_r <= 1'b0;
			rsvd_r     <= 1'b0;
		end else begin
			addr_err_r <= take && zext_misalign && !zext_rsvd;
			rsvd_r     <= take && zext_rsvd;
		end
	end

	assign addr_error     = addr_err_r;
	assign reserved_instr = rsvd_r;

	// APB slave
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
		(paddr == ADDR_COUNT);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (apb_wr && paddr == ADDR_CTRL) begin
			ctrl_r <= {26'h0, pwdata[CTRL_PRIV_HI:0]};
		end
	end

	// Sticky flags: a new event wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_addr_r <= 1'b0;
			sticky_rsvd_r <= 1'b0;
		end else begin
			if (addr_err_r) begin
				sticky_addr_r <= 1'b1;
			end else if (apb_wr && paddr == ADDR_STATUS && pwdata[STAT_ADDR_ERR]) begin
				sticky_addr_r <= 1'b0;
			end
			if (rsvd_r) begin
				sticky_rsvd_r <= 1'b1;
			end else if (apb_wr && paddr == ADDR_STATUS && pwdata[STAT_RSVD]) begin
				sticky_rsvd_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
		end else if (wb_fire) begin
			count_r <= count_r + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (apb_setup) begin
			case (paddr)
				ADDR_CTRL: prdata_r <= ctrl_r;
				ADDR_STATUS: prdata_r <= {29'h0, (state_r != ST_IDLE),
					sticky_rsvd_r, sticky_addr_r};
				ADDR_COUNT: prdata_r <= 32'(count_r);
				default: prdata_r <= 32'h0;
			endcase
		end
	end

endmodule : ulm_core

// ===== src/ulm_pkg.sv
// Constants, field layouts and carrier types of the partial-word load merge.
// Assumes a single core clock and an APB master on the same clock.
// What this block does
// - Right-partial load: opcode 100110, base 25..21, target 20..16, disp 15..0.
// - Zero-extended word load: opcode 101111, same field layout as other loads.
// - Virtual address is base plus displacement sign-extended from bit 15.
// - Right-partial load reads only the aligned word holding the byte.
// - Right-partial: addressed byte to low register byte, filling upward.
// - 64-bit mode: partial load result bit 31 copied into bits 63..32.
// - Result of the directly preceding load is forwarded to a partial load.
// - Partial loads never raise an alignment address error.
// - Zero-extended load writes the word and clears bits 63..32.
// - Zero-extended load raises address error if address bits 1..0 nonzero and the load is not reserved.
// - Zero-extended load in 32-bit user or supervisor mode is reserved.
// - Left-partial with little-endian memory clears physical bits 1..0.
// - Right-partial with big-endian memory clears physical bits 2..0.
// - Reverse-endian inverts physical address bits 2..0 before access.
// - Byte index from address bits 1..0, half from bit 2, flipped big-endian.
// - Access type: right-partial three minus index, left-partial the index.
// - Left-partial merge: addr 0 puts P into byte E, addr 7 loads I..L.
// - Right-partial merge: addr 0 loads all four, addr 7 only low byte.
// - Left-partial: addressed byte to top of low word, filling downward.
package ulm_pkg;

	localparam logic [5:0] OP_LOAD_LEFT  = 6'h22;
	localparam logic [5:0] OP_LOAD_RIGHT = 6'h26;
	localparam logic [5:0] OP_LOAD_ZEXT  = 6'h2F;

	localparam int OPC_HI  = 31;
	localparam int OPC_LO  = 26;
	localparam int BASE_HI = 25;
	localparam int BASE_LO = 21;
	localparam int TGT_HI  = 20;
	localparam int TGT_LO  = 16;
	localparam int DISP_HI = 15;

	localparam logic [2:0] ATYPE_WORD = 3'h3;
	localparam logic [1:0] BYTE_TOP   = 2'h3;

	localparam logic [1:0] PRIV_KERNEL = 2'h0;
	localparam logic [1:0] PRIV_SUPER  = 2'h1;
	localparam logic [1:0] PRIV_USER   = 2'h2;

	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_COUNT  = 12'h008;

	localparam int CTRL_MEM_BE = 0;
	localparam int CTRL_CPU_BE = 1;
	localparam int CTRL_REV    = 2;
	localparam int CTRL_MODE64 = 3;
	localparam int CTRL_PRIV_LO = 4;
	localparam int CTRL_PRIV_HI = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0008;

	localparam int STAT_ADDR_ERR = 0;
	localparam int STAT_RSVD     = 1;
	localparam int STAT_BUSY     = 2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XLAT = 2'b01,
		ST_REQ  = 2'b11,
		ST_RESP = 2'b10
	} ulm_state_type;

	typedef enum logic [1:0] {
		KIND_LEFT  = 2'h0,
		KIND_RIGHT = 2'h1,
		KIND_ZEXT  = 2'h2
	} ulm_kind_type;

	typedef struct packed {
		logic       mode64;
		logic [1:0] priv;
		logic       memory_big_endian;
		logic       processor_big_endian;
		logic       endian_reverse_select;
	} ulm_cfg_type;

	typedef struct packed {
		logic        valid;
		logic [4:0]  target_reg;
		logic [63:0] data;
	} ulm_result_type;

endpackage : ulm_pkg

// ===== bench/ulm_core_monitor.sv
// Concurrent checks on the load merge datapath ports.
// Assumes one-to-one translation and CTRL written only over APB.
`timescale 1ns/10ps
module ulm_core_monitor
	import ulm_pkg::*;
#(
	parameter int PADDR_W = 32,
	parameter int COUNT_W = 32
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic [11:0]          paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          pwdata,
	input wire logic                 issue_valid,
	input wire logic                 issue_ready,
	input wire logic [31:0]          issue_instr,
	input wire logic [63:0]          base_value,
	input wire logic [63:0]          virtual_addr,
	input wire logic [PADDR_W-1:0]   xlat_paddr,
	input wire logic                 mem_req_valid,
	input wire logic [PADDR_W-1:0]   mem_paddr,
	input wire logic [2:0]           mem_access_type,
	input wire ulm_result_type       result_out,
	input wire logic                 addr_error,
	input wire logic                 reserved_instr
);
	logic [31:0] ctrl_r;
	logic [5:0]  op_r;
	logic [4:0]  tgt_r;
	logic [31:0] va_r;
	logic [5:0]  op;
	logic        take;
	logic        is_p;
	logic        is_z;
	logic [1:0]  bidx;
	logic        z_ok;
	assign op = issue_instr[OPC_HI:OPC_LO];
	assign take = issue_valid && issue_ready;
	assign is_p = op == OP_LOAD_LEFT || op == OP_LOAD_RIGHT;
	assign is_z = op == OP_LOAD_ZEXT;
	assign bidx = virtual_addr[1:0] ^ {2{ctrl_r[CTRL_CPU_BE]}};
	assign z_ok = is_z && (base_value[1:0] + issue_instr[1:0]) == 2'h0 &&
		(ctrl_r[CTRL_MODE64] || ctrl_r[CTRL_PRIV_HI:CTRL_PRIV_LO] == PRIV_KERNEL);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= CTRL_RST;
		else if (psel && penable && pwrite && paddr == ADDR_CTRL)
			ctrl_r <= pwdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r  <= 6'h00;
			tgt_r <= 5'h00;
			va_r  <= 32'h0;
		end else if (take && (is_p || is_z)) begin
			op_r  <= op;
			tgt_r <= issue_instr[TGT_HI:TGT_LO];
			va_r  <= base_value[31:0] + {{16{issue_instr[15]}}, issue_instr[15:0]};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_part_noalign: assert property (take && is_p |=> !addr_error)
		else $error("partial load raised address error");
	chk_virtual_addr_sum: assert property (take && (is_p || z_ok) |=>
		virtual_addr[31:0] == va_r) else $error("virtual address wrong");
	chk_zext_misal: assert property (take && is_z &&
		(base_value[1:0] + issue_instr[1:0]) != 2'h0 |=> addr_error || reserved_instr)
		else $error("misaligned word load not refused");
	chk_zext_rsvd: assert property (take && is_z && !ctrl_r[CTRL_MODE64] &&
		(ctrl_r[CTRL_PRIV_HI:CTRL_PRIV_LO] == PRIV_USER ||
		ctrl_r[CTRL_PRIV_HI:CTRL_PRIV_LO] == PRIV_SUPER) |=> reserved_instr)
		else $error("word load in 32-bit mode not reserved");
	chk_access_type: assert property (mem_req_valid && op_r != OP_LOAD_ZEXT |->
		mem_access_type == (op_r == OP_LOAD_RIGHT ? 3'h3 - bidx : {1'b0, bidx}))
		else $error("access type wrong");
	chk_left_clear: assert property (mem_req_valid && op_r == OP_LOAD_LEFT &&
		!ctrl_r[CTRL_MEM_BE] |-> mem_paddr[1:0] == 2'h0) else $error("left low bits");
	chk_right_clear: assert property (mem_req_valid && op_r == OP_LOAD_RIGHT &&
		ctrl_r[CTRL_MEM_BE] |-> mem_paddr[2:0] == 3'h0) else $error("right low bits");
	chk_rev_xor: assert property (mem_req_valid && op_r == OP_LOAD_RIGHT &&
		!ctrl_r[CTRL_MEM_BE] |-> mem_paddr[2:0] == (xlat_paddr[2:0] ^ {3{ctrl_r[CTRL_REV]}}))
		else $error("reverse endian offset wrong");
	chk_zext_upper: assert property (result_out.valid && op_r == OP_LOAD_ZEXT |->
		result_out.data[63:32] == 32'h0) else $error("upper word not cleared");
	chk_sext_upper: assert property (result_out.valid && op_r != OP_LOAD_ZEXT &&
		ctrl_r[CTRL_MODE64] |-> result_out.data[63:32] == {32{result_out.data[31]}})
		else $error("upper word not sign extension");
	chk_res_target: assert property (result_out.valid |->
		result_out.target_reg == tgt_r) else $error("result target wrong");
	cov_right: cover property (take && op == OP_LOAD_RIGHT);
	cov_left_res: cover property (result_out.valid && op_r == OP_LOAD_LEFT);
	cov_addr_err: cover property (addr_error);
endmodule : ulm_core_monitor

bind ulm_core ulm_core_monitor #(.PADDR_W(PADDR_W), .COUNT_W(COUNT_W)) u_mon (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .issue_valid,
	.issue_ready, .issue_instr, .base_value, .virtual_addr, .xlat_paddr,
	.mem_req_valid, .mem_paddr, .mem_access_type, .result_out, .addr_error,
	.reserved_instr);

// ===== bench/ulm_mem_model.sv
// Translation and memory stage partner of the load merge datapath.
// Assumes one-to-one translation and one constant doubleword in memory.
`timescale 1ns/10ps
module ulm_mem_model #(
	parameter int          PADDR_W = 32,
	parameter logic [63:0] MEM_DW  = 64'h0
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [2:0]         lat,
	input  wire logic [63:0]        virtual_addr,
	output logic      [PADDR_W-1:0] xlat_paddr,
	input  wire logic               mem_req_valid,
	output logic                    mem_req_ready,
	output logic                    mem_rsp_valid,
	output logic      [63:0]        mem_rsp_data
);
	logic [2:0] wait_r;
	assign xlat_paddr = virtual_addr[PADDR_W-1:0];
	assign mem_req_ready = mem_req_valid && (wait_r >= lat);
	// Data outside a valid response shows the inverse so stale bytes never pass
	assign mem_rsp_data = mem_rsp_valid ? MEM_DW : ~MEM_DW;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r        <= 3'h0;
			mem_rsp_valid <= 1'b0;
		end else begin
			wait_r        <= (mem_req_valid && !mem_req_ready) ? wait_r + 3'h1 : 3'h0;
			mem_rsp_valid <= mem_req_valid && mem_req_ready;
		end
	end
endmodule : ulm_mem_model

// ===== bench/tb.sv
// Self-checking bench for the load merge datapath.
// Assumes ulm_pkg, the bound checker and the memory partner model.
`timescale 1ns/10ps
module tb;
	import ulm_pkg::*;
	localparam logic [63:0] MEM_DW = 64'h8182838475767778;
	localparam logic [63:0] OLD    = 64'h1112131415161718;
	localparam logic [63:0] BYP    = 64'h2122232425262728;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic [11:0]         paddr = 12'h0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                issue_valid = 1'b0;
	logic                issue_ready;
	logic [31:0]         issue_instr = 32'h0;
	logic [63:0]         base_value = 64'h0;
	logic [63:0]         target_value = 64'h0;
	logic [63:0]         virtual_addr;
	logic [31:0]         xlat_paddr;
	logic                mem_req_valid;
	logic                mem_req_ready;
	logic [31:0]         mem_paddr;
	logic [2:0]          mem_access_type;
	logic                mem_rsp_valid;
	logic [63:0]         mem_rsp_data;
	ulm_result_type      result_out;
	logic                addr_error;
	logic                reserved_instr;
	logic [2:0]          lat = 3'h0;
	logic [31:0]         rdat;
	logic                err;
	ulm_result_type      bypass = '0;
	logic [63:0]         reg9_m = OLD;
	int                  n_fail = 0;
	int                  check_count = 0;
	always #2.5 pclk = ~pclk;
	ulm_core #(.PADDR_W(32)) u_dut (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_ready,
		.issue_instr, .base_value, .target_value, .bypass_in(bypass), .virtual_addr,
		.xlat_paddr, .mem_req_valid, .mem_req_ready, .mem_paddr, .mem_access_type,
		.mem_rsp_valid, .mem_rsp_data, .result_out, .addr_error, .reserved_instr);
	ulm_mem_model #(.PADDR_W(32), .MEM_DW(MEM_DW)) u_mem (.pclk, .presetn, .lat,
		.virtual_addr, .xlat_paddr, .mem_req_valid, .mem_req_ready,
		.mem_rsp_valid, .mem_rsp_data);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string nm, input logic [63:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic hang(input logic ok);
		if (!ok) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : hang
	function automatic logic [63:0] mrg(input logic lf, input logic [2:0] va,
		input logic cbe, input logic m64, input logic [63:0] old);
		logic [1:0]  b;
		logic [31:0] mw;
		logic [31:0] t;
		b = va[1:0] ^ {2{cbe}};
		mw = (va[2] ^ cbe) ? MEM_DW[63:32] : MEM_DW[31:0];
		if (lf)
			t = (mw << (24 - 8 * b)) | (old[31:0] & (32'h00FFFFFF >> (8 * b)));
		else
			t = (mw >> (8 * b)) | (old[31:0] & ~(32'hFFFFFFFF >> (8 * b)));
		return m64 ? {{32{t[31]}}, t} : {old[63:32], t};
	endfunction : mrg
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
		hang(pready === 1'b1);
		rdat = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic issue(input logic [5:0] op, input logic [15:0] dp,
		input logic [63:0] bs, old);
		int k;
		@(posedge pclk);
		{issue_valid, issue_instr} <= {1'b1, op, 5'h03, 5'h09, dp};
		base_value <= bs;
		target_value <= old;
		k = 0;
		do begin @(posedge pclk); k++; end while (issue_ready !== 1'b1 && k < 50);
		hang(issue_ready === 1'b1);
	endtask : issue
	task automatic wait_res(output logic [63:0] d, output logic [1:0] x);
		int k;
		issue_valid <= 1'b0;
		k = 0;
		do begin @(negedge pclk); k++; end
		while (result_out.valid !== 1'b1 && {addr_error, reserved_instr} == 2'b00 && k < 50);
		hang(k < 50);
		d = result_out.data;
		x = {reserved_instr, addr_error};
		if (result_out.valid === 1'b1)
			check("target", {59'h0, result_out.target_reg}, 64'h9);
		@(posedge pclk);
	endtask : wait_res
	task automatic load(input logic [5:0] op, input logic [15:0] dp,
		input logic [63:0] bs, exp, input logic [1:0] xe);
		logic [63:0] d;
		logic [1:0]  x;
		issue(op, dp, bs, reg9_m);
		wait_res(d, x);
		check("exception", {62'h0, x}, {62'h0, xe});
		if (xe == 2'h0) begin
			check("data", d, exp);
			reg9_m = exp;
		end
	endtask : load
	task automatic t_regs();
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl_rst", {32'h0, rdat}, {32'h0, CTRL_RST});
		apb(1'b1, ADDR_CTRL, 32'h2F);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl_rw", {32'h0, rdat}, 64'h2F);
		apb(1'b0, 12'h0FC, 32'h0);
		check("unmapped", {63'h0, err}, 64'h1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_merge();
		logic [31:0] cf [4] = '{32'h8, 32'hB, 32'hC, 32'h0};
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_CTRL, cf[c]);
			for (int a = 0; a < 16; a++)
				load(a[3] ? OP_LOAD_LEFT : OP_LOAD_RIGHT, {13'h0, a[2:0]}, 64'h2000,
					mrg(a[3], a[2:0], cf[c][1], cf[c][3], reg9_m), 2'h0);
		end
		$display("t_merge done");
	endtask : t_merge
	task automatic t_zext();
		apb(1'b1, ADDR_CTRL, 32'h8);
		load(OP_LOAD_ZEXT, 16'hFFFC, 64'h2008, {32'h0, MEM_DW[63:32]}, 2'h0);
		check("virtual_addr", virtual_addr, 64'h2004);
		load(OP_LOAD_ZEXT, 16'h0001, 64'h2000, 64'h0, 2'h1);
		apb(1'b1, ADDR_CTRL, 32'h20);
		load(OP_LOAD_ZEXT, 16'h0000, 64'h2000, 64'h0, 2'h2);
		apb(1'b1, ADDR_CTRL, 32'h10);
		load(OP_LOAD_ZEXT, 16'h0000, 64'h2000, 64'h0, 2'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("status", {32'h0, rdat}, 64'h3);
		apb(1'b1, ADDR_STATUS, 32'h3);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("status_clr", {32'h0, rdat}, 64'h0);
		apb(1'b0, ADDR_COUNT, 32'h0);
		check("count", {32'h0, rdat}, 64'h41);
		$display("t_zext done");
	endtask : t_zext
	task automatic t_fwd();
		logic [63:0] d;
		logic [1:0]  x;
		apb(1'b1, ADDR_CTRL, 32'h8);
		lat <= 3'h3;
		bypass <= {1'b1, 5'h09, BYP};
		issue(OP_LOAD_RIGHT, 16'h0002, 64'h2000, OLD);
		bypass <= '0;
		issue(OP_LOAD_LEFT, 16'h0000, 64'h2000, OLD);
		wait_res(d, x);
		check("forward", d, mrg(1'b1, 3'h0, 1'b0, 1'b1,
			mrg(1'b0, 3'h2, 1'b0, 1'b1, BYP)));
		lat <= 3'h0;
		$display("t_fwd done");
	endtask : t_fwd
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_merge();
		t_zext();
		t_fwd();
		tally_and_finish();
	end
endmodule : tb
